// ===== rtl/mmc_meter_config.sv
/*
 * Measurement configuration and sequencing for the meter's converter path:
 * settings registers, autozero sequence, autoranging and overload flag.
 * Assumes the converter and front end run on CLOCK, answer each
 * CONV_START with one CONV_DONE pulse, and the host formats readings.
 */
// How it works
// - High-impedance input only on lowest three dc-voltage ranges.
// - Reset clears high-impedance input selection.
// - Configure turns high-impedance input off.
// - Line cycles map to fixed resolution fractions.
// - Integration time resets to ten line cycles.
// - Ac functions always integrate ten line cycles.
// - Line rejection only at 1, 10, 100 cycles.
// - Frequency gate time sets digits, default 100 ms.
// - Autozero on: zero after each reading, subtract.
// - Autozero off: one held zero, retaken on change.
// - Autozero choice limited per function.
// - Autozero enabled after reset.
// - Single-shot zero runs now, then held zero.
// - Explicit range selects it and stops autoranging.
// - Autoranging enabled after reset.
// - Step down below 10%, up above 120%.
// - Overload when over range and cannot step.
// - Frequency uses one 3 Hz range, zero without signal.
// - Ratio reference always autoranges; settings apply main.
// - Math uses the measurement's resolution and time.
`timescale 1ns/1ps
`include "mmc_params.svh"

module mmc_meter_config #(
  parameter int RANGE_W = 3,
  parameter int DATA_W = `MMC_DATA_W,
  parameter logic [2:0] MAX_RANGE = `MMC_MAX_RANGE
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic CMD_VALID,
  input wire mmc_pkg::mmc_cmd_t CMD,
  output logic CMD_READY,
  input wire logic MEAS_REQ,
  output logic MEAS_READY,
  output logic CONV_START,
  input wire logic CONV_DONE,
  input wire mmc_pkg::mmc_conv_t CONV_RESULT,
  output mmc_pkg::mmc_front_t FRONT,
  output logic [11:0] RESOLUTION,
  output logic [2:0] DIGITS,
  output logic NMR_OK,
  output logic AUTORANGE,
  output logic RANGE_IS_3HZ,
  output logic signed [DATA_W-1:0] READING,
  output logic signed [DATA_W-1:0] REF_READING,
  output logic READING_VALID,
  output logic OVERLOAD
);
  if (DATA_W != `MMC_DATA_W || RANGE_W != 3 || MAX_RANGE == 3'h0) begin
    $error("mmc_meter_config: unsupported parameter values");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_MEAS, ST_ZERO, ST_REF, ST_DONE
  } mmc_st_t;

  function automatic logic [DATA_W-1:0] magnitude(
      input logic signed [DATA_W-1:0] v);
    magnitude = v[DATA_W-1] ? DATA_W'(-v) : DATA_W'(v);
  endfunction

  function automatic mmc_pkg::mmc_zero_eff_t zero_eff(
      input mmc_pkg::mmc_func_t f, input mmc_pkg::mmc_zero_mode_t m);
    case (f)
      mmc_pkg::FN_DCV, mmc_pkg::FN_DCI, mmc_pkg::FN_OHM2:
        zero_eff = (m == mmc_pkg::AZ_ON) ? mmc_pkg::ZE_EACH : mmc_pkg::ZE_HELD;
      mmc_pkg::FN_OHM4, mmc_pkg::FN_RATIO: zero_eff = mmc_pkg::ZE_EACH;
      default: zero_eff = mmc_pkg::ZE_NONE;
    endcase
  endfunction

  mmc_st_t state, next_state;
  mmc_pkg::mmc_func_t func, next_func;
  mmc_pkg::mmc_plc_t line_cycle, next_plc;
  mmc_pkg::mmc_gate_t gate, next_gate;
  mmc_pkg::mmc_zero_mode_t zmode, next_zmode;
  logic [2:0] range, next_range, ref_range, next_ref_range;
  logic autorange, next_autorange, high_z, next_high_z;
  logic zero_stale, next_zero_stale, pre_zero, next_pre_zero;
  logic single_shot_zero_zero, next_single_shot_zero_zero, over, next_over;
  logic raw_nosig, next_raw_nosig, launch;
  logic signed [DATA_W-1:0] raw, next_raw, zero_val, next_zero_val;
  logic signed [DATA_W-1:0] ref_val, next_ref_val, next_reading;
  logic next_rvalid;
  mmc_pkg::mmc_zero_eff_t ze;
  mmc_pkg::mmc_front_t next_front;
  mmc_pkg::mmc_plc_t map_plc;
  logic [11:0] map_res;
  logic [2:0] map_digits, m_next, r_next;
  logic map_nmr, m_step, m_over, r_step, fixed_range;

  assign ze = zero_eff(func, zmode);
  assign fixed_range = func == mmc_pkg::FN_FREQ || func == mmc_pkg::FN_PER;
  // Commands wait while a conversion runs so a setting never moves under it.
  assign CMD_READY = state == ST_IDLE;
  assign MEAS_READY = state == ST_IDLE && !CMD_VALID;

  mmc_range_step #(.RANGE_W(RANGE_W), .DATA_W(DATA_W)) u_main_step (
    .range(range),
    .max_range(MAX_RANGE),
    .auto_en(autorange),
    .mag(magnitude(CONV_RESULT.data)),
    .next_range(m_next),
    .step(m_step),
    .over(m_over)
  );

  // The reference on the sense inputs ignores the user's range setting.
  mmc_range_step #(.RANGE_W(RANGE_W), .DATA_W(DATA_W)) u_ref_step (
    .range(ref_range),
    .max_range(MAX_RANGE),
    .auto_en(1'b1),
    .mag(magnitude(CONV_RESULT.data)),
    .next_range(r_next),
    .step(r_step),
    .over()
  );

  mmc_reso_map u_map (
    .func(next_func),
    .line_cycle(next_plc),
    .gate(next_gate),
    .plc_eff(map_plc),
    .res_code(map_res),
    .digits(map_digits),
    .nmr_ok(map_nmr)
  );

  always_comb begin
    next_state = state;
    next_func = func;
    next_plc = line_cycle;
    next_gate = gate;
    next_zmode = zmode;
    next_range = range;
    next_ref_range = ref_range;
    next_autorange = autorange;
    next_high_z = high_z;
    next_zero_stale = zero_stale;
    next_pre_zero = pre_zero;
    next_single_shot_zero_zero = single_shot_zero_zero;
    next_over = over;
    next_raw = raw;
    next_raw_nosig = raw_nosig;
    next_zero_val = zero_val;
    next_ref_val = ref_val;
    next_reading = READING;
    next_rvalid = 1'b0;
    launch = 1'b0;
    case (state)
      ST_IDLE: begin
        if (CMD_VALID) begin
          case (CMD.op)
            mmc_pkg::OP_CONFIGURE: begin
              next_func = CMD.func;
              next_high_z = 1'b0;
              next_zero_stale = 1'b1;
              if (CMD.arg[`MMC_ARG_EXPLICIT]) begin
                next_range = (CMD.arg[2:0] > MAX_RANGE) ? MAX_RANGE : CMD.arg[2:0];
                next_autorange = 1'b0;
              end else begin
                next_autorange = 1'b1;
              end
            end
            mmc_pkg::OP_HIGH_Z: next_high_z = CMD.arg[0];
            mmc_pkg::OP_PLC: begin
              if (CMD.arg[2:0] <= 3'(mmc_pkg::PLC_100)) begin
                next_plc = mmc_pkg::mmc_plc_t'(CMD.arg[2:0]);
                next_zero_stale = zero_stale || next_plc != line_cycle;
              end
            end
            mmc_pkg::OP_GATE: begin
              if (CMD.arg[1:0] <= 2'(mmc_pkg::GATE_1S)) begin
                next_gate = mmc_pkg::mmc_gate_t'(CMD.arg[1:0]);
              end
            end
            mmc_pkg::OP_ZERO: begin
              if (CMD.arg[1:0] == 2'(mmc_pkg::AZ_ON)) begin
                next_zmode = mmc_pkg::AZ_ON;
              end else if (CMD.arg[1:0] == 2'(mmc_pkg::AZ_OFF)) begin
                // Selecting off alone keeps the present held zero.
                next_zmode = mmc_pkg::AZ_OFF;
              end else if (CMD.arg[1:0] == 2'(mmc_pkg::AZ_SINGLE_SHOT_ZERO)) begin
                next_zmode = mmc_pkg::AZ_OFF;
                if (zero_eff(func, mmc_pkg::AZ_OFF) == mmc_pkg::ZE_HELD) begin
                  next_single_shot_zero_zero = 1'b1;
                  next_state = ST_ZERO;
                  launch = 1'b1;
                end
              end
            end
            mmc_pkg::OP_RANGE: begin
              next_range = (CMD.arg[2:0] > MAX_RANGE) ? MAX_RANGE : CMD.arg[2:0];
              next_autorange = 1'b0;
              next_zero_stale = zero_stale || next_range != range;
            end
            mmc_pkg::OP_AUTORANGE: next_autorange = CMD.arg[0];
            default: next_state = ST_IDLE;
          endcase
        end else if (MEAS_REQ) begin
          next_over = 1'b0;
          launch = 1'b1;
          if (ze == mmc_pkg::ZE_HELD && zero_stale) begin
            next_pre_zero = 1'b1;
            next_state = ST_ZERO;
          end else begin
            next_state = ST_MEAS;
          end
        end
      end
      ST_MEAS: begin
        if (CONV_DONE) begin
          next_raw = CONV_RESULT.data;
          next_raw_nosig = CONV_RESULT.no_signal;
          launch = 1'b1;
          if (m_step && !fixed_range) begin
            // A new range needs a fresh reading and, when held, a new zero.
            next_range = m_next;
            next_zero_stale = 1'b1;
            if (ze == mmc_pkg::ZE_HELD) begin
              next_pre_zero = 1'b1;
              next_state = ST_ZERO;
            end
          end else begin
            next_over = m_over && !fixed_range;
            if (ze == mmc_pkg::ZE_EACH) begin
              next_state = ST_ZERO;
            end else if (func == mmc_pkg::FN_RATIO) begin
              next_state = ST_REF;
            end else begin
              next_state = ST_DONE;
              launch = 1'b0;
            end
          end
        end
      end
      ST_ZERO: begin
        if (CONV_DONE) begin
          next_zero_val = CONV_RESULT.data;
          next_zero_stale = 1'b0;
          next_single_shot_zero_zero = 1'b0;
          next_pre_zero = 1'b0;
          if (single_shot_zero_zero) begin
            next_state = ST_IDLE;
          end else if (pre_zero) begin
            next_state = ST_MEAS;
            launch = 1'b1;
          end else if (func == mmc_pkg::FN_RATIO) begin
            next_state = ST_REF;
            launch = 1'b1;
          end else begin
            next_state = ST_DONE;
          end
        end
      end
      ST_REF: begin
        if (CONV_DONE) begin
          next_ref_val = CONV_RESULT.data;
          if (r_step) begin
            next_ref_range = r_next;
            launch = 1'b1;
          end else begin
            next_state = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        if (fixed_range && raw_nosig) begin
          next_reading = '0;
        end else if (ze == mmc_pkg::ZE_NONE) begin
          next_reading = raw;
        end else begin
          next_reading = DATA_W'(raw - zero_val);
        end
        next_rvalid = 1'b1;
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    next_front.range = (next_state == ST_REF) ? next_ref_range : next_range;
    next_front.disconnect = next_state == ST_ZERO;
    next_front.sense_path = next_state == ST_REF;
    next_front.high_z = next_high_z && next_func == mmc_pkg::FN_DCV &&
                        next_range <= `MMC_HIGH_Z_TOP;
    next_front.line_cycle = map_plc;
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      state <= ST_IDLE;
      func <= mmc_pkg::FN_DCV;
      line_cycle <= mmc_pkg::PLC_10;
      gate <= mmc_pkg::GATE_100MS;
      zmode <= mmc_pkg::AZ_ON;
      range <= 3'h0;
      ref_range <= 3'h0;
      autorange <= 1'b1;
      high_z <= 1'b0;
      zero_stale <= 1'b1;
      pre_zero <= 1'b0;
      single_shot_zero_zero <= 1'b0;
      over <= 1'b0;
      raw <= '0;
      raw_nosig <= 1'b0;
      zero_val <= '0;
      ref_val <= '0;
      READING <= '0;
      REF_READING <= '0;
      READING_VALID <= 1'b0;
      OVERLOAD <= 1'b0;
      CONV_START <= 1'b0;
      FRONT <= '{1'b0, 1'b0, 1'b0, 3'h0, mmc_pkg::PLC_10};
      RESOLUTION <= `MMC_RES_10;
      DIGITS <= `MMC_DIGITS_100MS;
      NMR_OK <= 1'b1;
      AUTORANGE <= 1'b1;
      RANGE_IS_3HZ <= 1'b0;
    end else begin
      state <= next_state;
      func <= next_func;
      line_cycle <= next_plc;
      gate <= next_gate;
      zmode <= next_zmode;
      range <= next_range;
      ref_range <= next_ref_range;
      autorange <= next_autorange;
      high_z <= next_high_z;
      zero_stale <= next_zero_stale;
      pre_zero <= next_pre_zero;
      single_shot_zero_zero <= next_single_shot_zero_zero;
      over <= next_over;
      raw <= next_raw;
      raw_nosig <= next_raw_nosig;
      zero_val <= next_zero_val;
      ref_val <= next_ref_val;
      READING <= next_reading;
      REF_READING <= next_rvalid ? ref_val : REF_READING;
      READING_VALID <= next_rvalid;
      OVERLOAD <= next_rvalid ? over : OVERLOAD;
      CONV_START <= launch;
      FRONT <= next_front;
      // Math results share these figures with the active function.
      RESOLUTION <= map_res;
      DIGITS <= map_digits;
      NMR_OK <= map_nmr;
      AUTORANGE <= next_autorange;
      RANGE_IS_3HZ <= next_func == mmc_pkg::FN_FREQ ||
                      next_func == mmc_pkg::FN_PER;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  sequence s_cfg_taken;
    CMD_VALID && CMD_READY && CMD.op == mmc_pkg::OP_CONFIGURE;
  endsequence
  sequence s_meas_done_each;
    state == ST_MEAS && CONV_DONE && !(m_step && !fixed_range) &&
    ze == mmc_pkg::ZE_EACH;
  endsequence

  property p_high_z_ranges;
    FRONT.high_z |-> func == mmc_pkg::FN_DCV && range <= 3'h2;
  endproperty
  a_high_z_ranges: assert property (p_high_z_ranges) else $error("high-z off range");
  property p_rst_high_z;
    $rose(NRST) |-> !FRONT.high_z && !high_z;
  endproperty
  a_rst_high_z: assert property (p_rst_high_z) else $error("high-z after reset");
  property p_cfg_high_z;
    s_cfg_taken |=> !high_z ##0 !FRONT.high_z;
  endproperty
  a_cfg_high_z: assert property (p_cfg_high_z) else $error("configure kept high-z");
  property p_rst_plc;
    $rose(NRST) |-> line_cycle == mmc_pkg::PLC_10 && RESOLUTION == 12'h00A;
  endproperty
  a_rst_plc: assert property (p_rst_plc) else $error("reset plc wrong");
  property p_ac_plc;
    (func == mmc_pkg::FN_ACV || func == mmc_pkg::FN_ACI) |->
      FRONT.line_cycle == mmc_pkg::PLC_10;
  endproperty
  a_ac_plc: assert property (p_ac_plc) else $error("ac plc not ten");
  property p_each_zero;
    s_meas_done_each |=> FRONT.disconnect && CONV_START;
  endproperty
  a_each_zero: assert property (p_each_zero) else $error("no zero after reading");
  property p_ac_no_zero;
    FRONT.disconnect |-> func != mmc_pkg::FN_ACV && func != mmc_pkg::FN_ACI;
  endproperty
  a_ac_no_zero: assert property (p_ac_no_zero) else $error("zero on ac");
  property p_rst_auto;
    $rose(NRST) |-> AUTORANGE && zmode == mmc_pkg::AZ_ON;
  endproperty
  a_rst_auto: assert property (p_rst_auto) else $error("reset modes wrong");
  property p_step_up;
    state == ST_MEAS && CONV_DONE && autorange && !fixed_range &&
    magnitude(CONV_RESULT.data) > 24'h124F80 && range < MAX_RANGE |=>
      range == $past(range) + 3'h1;
  endproperty
  a_step_up: assert property (p_step_up) else $error("no upward step");
  property p_overload;
    state == ST_MEAS && CONV_DONE && m_over && !m_step && !fixed_range |=>
      ##[1:1000] READING_VALID && OVERLOAD;
  endproperty
  a_overload: assert property (p_overload) else $error("overload lost");
  property p_stable_cfg;
    state != ST_IDLE |=> $stable(func) && $stable(line_cycle) && $stable(autorange);
  endproperty
  a_stable_cfg: assert property (p_stable_cfg) else $error("setting moved");
endmodule

// ===== rtl/mmc_params.svh
/*
 * Constants for the meter configuration block: reset values, range limits,
 * autorange thresholds and the full-scale count of the converter.
 * Assumes it is included by its bare name from the package and the modules.
 */
`ifndef MMC_PARAMS_SVH
`define MMC_PARAMS_SVH

// Width of a converter reading in bits.
`define MMC_DATA_W 24
// Counts that stand for 100 percent of the present range.
`define MMC_FULL_SCALE 24'h0F4240
// Autorange thresholds in percent of the present range.
`define MMC_DOWN_PCT 10
`define MMC_UP_PCT 120
// Highest range index on which the high-impedance path may be used.
`define MMC_HIGH_Z_TOP 3'h2
// Highest range index of the largest function.
`define MMC_MAX_RANGE 3'h4
// Resolution in units of 1e-7 of full scale for each line-cycle setting.
`define MMC_RES_0P02 12'h3E8
`define MMC_RES_0P2 12'h064
`define MMC_RES_1 12'h01E
`define MMC_RES_10 12'h00A
`define MMC_RES_100 12'h003
// Half-digit counts for the gate times 10 ms, 100 ms and 1 s.
`define MMC_DIGITS_10MS 3'h4
`define MMC_DIGITS_100MS 3'h5
`define MMC_DIGITS_1S 3'h6
// Command argument fields.
`define MMC_ARG_EXPLICIT 7

`endif

// ===== rtl/mmc_pkg.sv
/*
 * Types shared by the meter configuration block: functions, settings,
 * commands and the bundles that pass to the converter and front end.
 * Assumes mmc_params.svh is on the include path.
 */
`include "mmc_params.svh"

package mmc_pkg;
  typedef enum logic [3:0] {
    FN_DCV, FN_DCI, FN_OHM2, FN_OHM4, FN_ACV, FN_ACI, FN_FREQ, FN_PER, FN_RATIO
  } mmc_func_t;
  typedef enum logic [2:0] {
    PLC_0P02, PLC_0P2, PLC_1, PLC_10, PLC_100
  } mmc_plc_t;
  typedef enum logic [1:0] {GATE_10MS, GATE_100MS, GATE_1S} mmc_gate_t;
  typedef enum logic [1:0] {AZ_ON, AZ_OFF, AZ_SINGLE_SHOT_ZERO} mmc_zero_mode_t;
  typedef enum logic [1:0] {ZE_NONE, ZE_EACH, ZE_HELD} mmc_zero_eff_t;
  typedef enum logic [2:0] {
    OP_CONFIGURE, OP_HIGH_Z, OP_PLC, OP_GATE, OP_ZERO, OP_RANGE, OP_AUTORANGE
  } mmc_op_t;
  typedef struct packed {
    mmc_op_t op;
    mmc_func_t func;
    logic [7:0] arg;
  } mmc_cmd_t;
  typedef struct packed {
    logic signed [`MMC_DATA_W-1:0] data;
    logic no_signal;
  } mmc_conv_t;
  typedef struct packed {
    logic high_z;
    logic disconnect;
    logic sense_path;
    logic [2:0] range;
    mmc_plc_t line_cycle;
  } mmc_front_t;
endpackage

// ===== rtl/mmc_range_step.sv
/*
 * Autorange decision for one reading: step down below the lower threshold,
 * step up above the upper one, flag overload when above it and no step up is possible.
 * Assumes a magnitude in counts against a full-scale count on the same clock.
 */
`timescale 1ns/1ps
`include "mmc_params.svh"

module mmc_range_step #(
  parameter int RANGE_W = 3,
  parameter int DATA_W = 24
) (
  input wire logic [RANGE_W-1:0] range,
  input wire logic [RANGE_W-1:0] max_range,
  input wire logic auto_en,
  input wire logic [DATA_W-1:0] mag,
  output logic [RANGE_W-1:0] next_range,
  output logic step,
  output logic over
);
  logic [DATA_W+7:0] scaled;
  logic [DATA_W+7:0] low_lim;
  logic [DATA_W+7:0] up_lim;
  logic below;
  logic above;

  // Percent comparison without a divider: 100*mag against pct*full scale.
  assign scaled = {8'h00, mag} * (DATA_W+8)'(100);
  assign low_lim = {8'h00, DATA_W'(`MMC_FULL_SCALE)} * (DATA_W+8)'(`MMC_DOWN_PCT);
  assign up_lim = {8'h00, DATA_W'(`MMC_FULL_SCALE)} * (DATA_W+8)'(`MMC_UP_PCT);
  assign below = scaled < low_lim;
  assign above = scaled > up_lim;

  always_comb begin
    next_range = range;
    step = 1'b0;
    if (auto_en && above && range < max_range) begin
      next_range = range + RANGE_W'(1);
      step = 1'b1;
    end else if (auto_en && below && range != '0) begin
      next_range = range - RANGE_W'(1);
      step = 1'b1;
    end
  end

  assign over = above && (!auto_en || range >= max_range);
endmodule

// ===== rtl/mmc_reso_map.sv
/*
 * Maps function, line-cycle setting and gate time to the effective
 * integration time, resolution, digits and line-noise rejection flag.
 * Assumes purely combinational use; the caller registers the results.
 */
`timescale 1ns/1ps
`include "mmc_params.svh"

module mmc_reso_map (
  input wire mmc_pkg::mmc_func_t func,
  input wire mmc_pkg::mmc_plc_t line_cycle,
  input wire mmc_pkg::mmc_gate_t gate,
  output mmc_pkg::mmc_plc_t plc_eff,
  output logic [11:0] res_code,
  output logic [2:0] digits,
  output logic nmr_ok
);
  always_comb begin
    plc_eff = line_cycle;
    if (func == mmc_pkg::FN_ACV || func == mmc_pkg::FN_ACI) begin
      plc_eff = mmc_pkg::PLC_10;
    end
    case (plc_eff)
      mmc_pkg::PLC_0P02: res_code = `MMC_RES_0P02;
      mmc_pkg::PLC_0P2: res_code = `MMC_RES_0P2;
      mmc_pkg::PLC_1: res_code = `MMC_RES_1;
      mmc_pkg::PLC_10: res_code = `MMC_RES_10;
      default: res_code = `MMC_RES_100;
    endcase
    nmr_ok = plc_eff == mmc_pkg::PLC_1 || plc_eff == mmc_pkg::PLC_10 ||
             plc_eff == mmc_pkg::PLC_100;
    case (gate)
      mmc_pkg::GATE_10MS: digits = `MMC_DIGITS_10MS;
      mmc_pkg::GATE_1S: digits = `MMC_DIGITS_1S;
      default: digits = `MMC_DIGITS_100MS;
    endcase
  end
endmodule

// ===== test/mmc_conv_model.sv
/* Converter and front-end model: one CONV_DONE for each CONV_START.
 * Assumes FRONT is settled in the cycle that carries CONV_START. */
`timescale 1ns/1ps
module mmc_conv_model (
  input wire logic CLOCK,
  input wire logic CONV_START,
  input wire mmc_pkg::mmc_front_t FRONT,
  input wire logic signed [23:0] main_val,
  input wire logic signed [23:0] zero_val,
  input wire logic no_sig,
  input wire logic slow,
  output logic CONV_DONE,
  output mmc_pkg::mmc_conv_t CONV_RESULT
);
  int wait_n = 0;
  logic signed [23:0] pick = '0;
  initial CONV_DONE = 1'b0;
  initial CONV_RESULT = '0;
  always @(posedge CLOCK) begin
    CONV_DONE <= 1'b0;
    // Data toggles outside the done pulse, so stale data is never a match.
    CONV_RESULT.data <= ~CONV_RESULT.data;
    if (CONV_START === 1'b1) begin
      wait_n <= slow ? 7 : 1;
      pick <= FRONT.disconnect ? zero_val : main_val;
    end else if (wait_n > 1) begin
      wait_n <= wait_n - 1;
    end else if (wait_n == 1) begin
      wait_n <= 0;
      CONV_DONE <= 1'b1;
      CONV_RESULT <= {pick, no_sig};
    end
  end
endmodule

// ===== test/mmc_meter_config_test.sv
/* Self-checking bench for mmc_meter_config with a converter model.
 * Assumes the rtl header and package are compiled first. */
`timescale 1ns/1ps
module mmc_meter_config_test;
  logic CLOCK = 0, NRST = 0, CMD_VALID = 0, MEAS_REQ = 0;
  logic no_sig = 0, slow = 0, CMD_READY, MEAS_READY, CONV_START, CONV_DONE;
  logic NMR_OK, AUTORANGE, RANGE_IS_3HZ, READING_VALID, OVERLOAD;
  logic [11:0] RESOLUTION;
  logic [2:0] DIGITS;
  logic signed [23:0] READING, REF_READING, mv = 0, zv = 0;
  mmc_pkg::mmc_cmd_t CMD = '0;
  mmc_pkg::mmc_front_t FRONT;
  mmc_pkg::mmc_conv_t CONV_RESULT;
  int err_count = 0, cmp_count = 0, n_st = 0, n_rv = 0, s, r;

  initial forever #2 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    if (CONV_START === 1'b1) n_st++;
    if (READING_VALID === 1'b1) n_rv++;
  end

  mmc_meter_config uut (.CLOCK(CLOCK), .NRST(NRST), .CMD_VALID(CMD_VALID),
    .CMD(CMD), .CMD_READY(CMD_READY), .MEAS_REQ(MEAS_REQ),
    .MEAS_READY(MEAS_READY), .CONV_START(CONV_START), .CONV_DONE(CONV_DONE),
    .CONV_RESULT(CONV_RESULT), .FRONT(FRONT), .RESOLUTION(RESOLUTION),
    .DIGITS(DIGITS), .NMR_OK(NMR_OK), .AUTORANGE(AUTORANGE),
    .RANGE_IS_3HZ(RANGE_IS_3HZ), .READING(READING),
    .REF_READING(REF_READING), .READING_VALID(READING_VALID),
    .OVERLOAD(OVERLOAD));
  mmc_conv_model conv (.CLOCK(CLOCK), .CONV_START(CONV_START), .FRONT(FRONT),
    .main_val(mv), .zero_val(zv), .no_sig(no_sig), .slow(slow),
    .CONV_DONE(CONV_DONE), .CONV_RESULT(CONV_RESULT));

  task close_out;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask
  // Every wait is bounded; a hang counts as a mismatch and ends the run.
  // The index picks 0 command ready, 1 measure ready, 2 reading valid.
  task automatic await(input int which);
    int n = 0;
    logic [2:0] seen;
    do begin
      @(negedge CLOCK);
      n++;
      seen = {READING_VALID, MEAS_READY, CMD_READY};
    end while (seen[which] !== 1'b1 && n < 300);
    if (seen[which] !== 1'b1) begin
      err_count++;
      close_out;
    end
  endtask
  task do_reset;
    @(posedge CLOCK) NRST <= 1'b0;
    repeat (3) @(posedge CLOCK);
    NRST <= 1'b1;
    @(negedge CLOCK);
  endtask
  task send(input logic [2:0] op, input logic [3:0] f, input logic [7:0] a);
    @(posedge CLOCK);
    CMD_VALID <= 1'b1;
    CMD <= {op, f, a};
    await(0);
    @(posedge CLOCK) CMD_VALID <= 1'b0;
    @(negedge CLOCK);
  endtask
  task meas(input logic signed [23:0] m, input logic signed [23:0] z);
    s = n_st;
    r = n_rv;
    @(posedge CLOCK);
    mv <= m;
    zv <= z;
    MEAS_REQ <= 1'b1;
    await(1);
    @(posedge CLOCK) MEAS_REQ <= 1'b0;
    await(2);
    // One more edge so the pulse counters have taken in this reading.
    @(negedge CLOCK);
  endtask

  task t_reset;
    do_reset;
    chk("high_z", 0, FRONT.high_z);
    chk("plc", 3, FRONT.line_cycle);
    chk("resolution", 12'h00A, RESOLUTION);
    chk("autorange", 1, AUTORANGE);
    chk("digits", 5, DIGITS);
    meas(24'sd1000, 24'sd10);
    chk("reading", 24'sd990, READING);
    chk("starts", 2, n_st - s);
  endtask
  task t_high_z;
    send(1, 0, 8'h01);
    chk("high_z", 1, FRONT.high_z);
    do_reset;
    chk("high_z", 0, FRONT.high_z);
    send(1, 0, 8'h01);
    send(0, 0, 8'h83);
    chk("high_z", 0, FRONT.high_z);
    send(1, 0, 8'h01);
    chk("high_z", 0, FRONT.high_z);
    send(0, 1, 8'h80);
    send(1, 1, 8'h01);
    chk("high_z", 0, FRONT.high_z);
  endtask
  task automatic t_plc;
    logic [11:0] rt [5] = '{12'h3E8, 12'h064, 12'h01E, 12'h00A, 12'h003};
    send(0, 0, 8'h80);
    for (int p = 0; p < 5; p++) begin
      send(2, 0, p[7:0]);
      chk("resolution", rt[p], RESOLUTION);
      chk("nmr", p >= 2, NMR_OK);
    end
    send(0, 4, 8'h80);
    send(2, 4, 8'h01);
    chk("plc", 3, FRONT.line_cycle);
  endtask
  task t_freq;
    send(0, 6, 8'h00);
    chk("range_3hz", 1, RANGE_IS_3HZ);
    for (int g = 0; g < 3; g++) begin
      send(3, 6, g[7:0]);
      chk("digits", 4 + g, DIGITS);
    end
    no_sig <= 1'b1;
    meas(24'sd5000, 24'sd0);
    chk("reading", 0, READING);
    no_sig <= 1'b0;
  endtask
  task t_zero;
    send(0, 0, 8'h80);
    send(4, 0, 8'h01);
    meas(24'sd1000, 24'sd10);
    chk("starts", 2, n_st - s);
    meas(24'sd1000, 24'sd20);
    chk("reading", 24'sd990, READING);
    chk("starts", 1, n_st - s);
    send(2, 0, 8'h02);
    meas(24'sd1000, 24'sd20);
    chk("reading", 24'sd980, READING);
    send(4, 0, 8'h02);
    meas(24'sd1000, 24'sd30);
    chk("starts", 2, n_st - s);
    chk("readings", 1, n_rv - r);
    chk("reading", 24'sd980, READING);
    send(4, 0, 8'h01);
    meas(24'sd1000, 24'sd40);
    chk("starts", 1, n_st - s);
    send(0, 3, 8'h80);
    send(4, 3, 8'h01);
    meas(24'sd1000, 24'sd10);
    chk("starts", 2, n_st - s);
    send(0, 4, 8'h80);
    meas(24'sd1000, 24'sd10);
    chk("starts", 1, n_st - s);
    chk("reading", 24'sd1000, READING);
  endtask
  task t_range;
    slow <= 1'b1;
    send(0, 0, 8'h00);
    meas(24'sd1200000, 24'sd0);
    chk("range", 0, FRONT.range);
    meas(24'sd2000000, 24'sd0);
    chk("range", 4, FRONT.range);
    chk("overload", 1, OVERLOAD);
    meas(24'sd100000, 24'sd0);
    chk("range", 4, FRONT.range);
    meas(24'sd50000, 24'sd0);
    chk("range", 0, FRONT.range);
    chk("overload", 0, OVERLOAD);
    send(5, 0, 8'h01);
    chk("autorange", 0, AUTORANGE);
    meas(24'sd2000000, 24'sd0);
    chk("range", 1, FRONT.range);
    chk("overload", 1, OVERLOAD);
    slow <= 1'b0;
  endtask
  task t_ratio;
    send(0, 8, 8'h80);
    meas(24'sd2000000, 24'sd10);
    chk("reading", 24'sd1999990, READING);
    chk("ref_reading", 24'sd2000000, REF_READING);
    chk("range", 0, FRONT.range);
    chk("overload", 1, OVERLOAD);
    chk("starts", 7, n_st - s);
    send(6, 8, 8'h01);
    chk("autorange", 1, AUTORANGE);
  endtask

  initial begin
    t_reset;
    t_high_z;
    t_plc;
    t_freq;
    t_zero;
    t_range;
    t_ratio;
    close_out;
  end
endmodule
